// ===== design/sld_pin_if.sv
/*
  Interface carrying the filtered control pin levels from the synchroniser to the core.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface sld_pin_if;
  logic [sld_pkg::NPIN-1:0] lvl;
  modport src (output lvl);
  modport dst (input lvl);
endinterface // sld_pin_if

// ===== design/sld_pkg.sv
/*
  Constants shared by the serial-in latched driver core and its pin synchroniser.
  Assumes one 100 MHz system clock; all four control pins are asynchronous to it.
*/
// Functional notes
// R1: Rising shift clock loads serial data into first shift stage.
// R2: Each rising shift clock moves all bits one stage toward cascade output.
// R3: Host sets serial data before raising the shift clock.
// R4: Strobe high copies all eight shift stages into the eight latch bits.
// R5: Latch stays transparent, following shift contents, while strobe stays high.
// R6: Strobe low keeps latch contents unchanged.
// R7: Output enable low drives each output from its latch bit.
// R8: Output enable high forces all eight outputs low.
// R9: Output enable never alters shift register or latch contents.
// R10: Host with strobe tied high should hold output enable high while loading.
// R11: Cascade output changes only at rising shift clock edges, stable between.
package sld_pkg;
  localparam int STAGES = 8;
  localparam int SYNC_DEPTH = 3;
  localparam int NPIN = 4;
  localparam int IDX_DATA = 0;
  localparam int IDX_SCLK = 1;
  localparam int IDX_STB = 2;
  localparam int IDX_OEN = 3;
  localparam logic [STAGES-1:0] STAGE_RST = 8'h00;
  localparam logic [STAGES-1:0] OUT_OFF = 8'h00;
  localparam logic [NPIN-1:0] PIN_RST = 4'h0;
endpackage

// ===== design/sld_sync.sv
/*
  Three-flop synchroniser with agreement filter for the asynchronous control pins.
  Assumes pins are quasi-static compared with the 10 ns system clock.
*/
`timescale 1ns/1ps
module sld_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [sld_pkg::NPIN-1:0] raw,
  sld_pin_if.src pins
);
  // One chain per pin; level only moves when stages two and three agree
  genvar i;
  generate
    for (i = 0; i < sld_pkg::NPIN; i++) begin : g_pin
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic filt_r;
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          s1_r <= sld_pkg::PIN_RST[i];
          s2_r <= sld_pkg::PIN_RST[i];
          s3_r <= sld_pkg::PIN_RST[i];
          filt_r <= sld_pkg::PIN_RST[i];
        end else begin
          s1_r <= raw[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin // Agreement rejects a metastable settle
            filt_r <= s3_r;
          end
        end
      end
      assign pins.lvl[i] = filt_r;
    end
  endgenerate
endmodule // sld_sync

// ===== design/sld_top.sv
/*
  Eight-stage serial-in shift register, strobed transparent latch and gated outputs.
  Assumes the host drives data, shift clock, strobe and output enable as slow pins.
*/
`timescale 1ns/1ps
module sld_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ser_in,
  input wire logic shift_clk,
  input wire logic strobe,
  input wire logic out_en_n,
  output logic ser_out,
  output logic [sld_pkg::STAGES-1:0] drv_out
);
  sld_pin_if pins ();
  logic sclk_prev_r;
  logic rise;
  logic data;
  logic stb;
  logic oe_n;
  logic [sld_pkg::STAGES-1:0] shift_r;
  logic [sld_pkg::STAGES-1:0] shift_nxt;
  logic [sld_pkg::STAGES-1:0] latch_r;
  logic [sld_pkg::STAGES-1:0] latch_nxt;
  logic ser_out_r;
  logic [sld_pkg::STAGES-1:0] drv_out_r;

  sld_sync u_sync (
    .clk (clk),
    .rst_n (rst_n),
    .raw ({out_en_n, strobe, shift_clk, ser_in}),
    .pins (pins.src)
  );

  // Filtered pin levels
  assign data = pins.lvl[sld_pkg::IDX_DATA];
  assign stb = pins.lvl[sld_pkg::IDX_STB];
  assign oe_n = pins.lvl[sld_pkg::IDX_OEN];
  // Data and clock share the same latency, so host setup order is preserved
  assign rise = pins.lvl[sld_pkg::IDX_SCLK] & ~sclk_prev_r; // R3

  // Shift clock edge finder
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= pins.lvl[sld_pkg::IDX_SCLK];
    end
  end

  // Next shift contents: stage 0 takes data, the rest move toward stage 7
  always_comb begin
    shift_nxt = shift_r;
    if (rise) begin
      shift_nxt = {shift_r[sld_pkg::STAGES-2:0], data}; // R1 R2
    end
  end

  // Latch follows the fresh shift value so transparency has no extra lag
  always_comb begin
    latch_nxt = latch_r; // R6
    if (stb) begin
      latch_nxt = shift_nxt; // R4 R5
    end
  end

  // Shift register and cascade stage; output enable is not a term here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_r <= sld_pkg::STAGE_RST;
      ser_out_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt; // R9
      ser_out_r <= shift_nxt[sld_pkg::STAGES-1]; // R11
    end
  end

  // Latch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_r <= sld_pkg::STAGE_RST;
    end else begin
      latch_r <= latch_nxt; // R9
    end
  end

  // Output gating; disabled outputs sit low, never floating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drv_out_r <= sld_pkg::OUT_OFF;
    end else if (oe_n) begin
      drv_out_r <= sld_pkg::OUT_OFF; // R8
    end else begin
      drv_out_r <= latch_nxt; // R7
    end
  end

  assign ser_out = ser_out_r;
  assign drv_out = drv_out_r;

  // Checks on the core
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_rise;
    rise;
  endsequence
  sequence s_stb_held;
    stb ##1 stb;
  endsequence
  sequence s_on_held;
    !oe_n ##1 !oe_n;
  endsequence

  property p_capture;
    s_rise |=> shift_r[0] == $past(data);
  endproperty
  a_capture: assert property (p_capture) else $error("first stage missed data"); // R1

  property p_shift;
    s_rise |=> shift_r[sld_pkg::STAGES-1:1] == $past(shift_r[sld_pkg::STAGES-2:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("stages did not move on"); // R2

  property p_latch_copy;
    stb |=> latch_r == shift_r;
  endproperty
  a_latch_copy: assert property (p_latch_copy) else $error("latch missed copy"); // R4

  property p_transparent;
    s_stb_held ##0 s_rise |=> latch_r[0] == $past(data);
  endproperty
  a_transparent: assert property (p_transparent) else $error("latch not transparent"); // R5

  property p_latch_hold;
    !stb |=> $stable(latch_r);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed"); // R6

  property p_out_on;
    !oe_n |=> drv_out == latch_r;
  endproperty
  a_out_on: assert property (p_out_on) else $error("output not latch state"); // R7

  property p_out_off;
    oe_n |=> drv_out == sld_pkg::OUT_OFF;
  endproperty
  a_out_off: assert property (p_out_off) else $error("output not forced low"); // R8

  property p_oe_neutral;
    $changed(oe_n) && !rise && !stb |=> $stable(shift_r) && $stable(latch_r);
  endproperty
  a_oe_neutral: assert property (p_oe_neutral) else $error("enable altered storage"); // R9

  property p_cascade;
    !rise |=> $stable(ser_out) ##0 ser_out == shift_r[sld_pkg::STAGES-1];
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade moved off edge"); // R11

  // Between shift edges the register must sit still
  property p_shift_hold;
    !rise |=> $stable(shift_r);
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("stages moved off edge"); // R2

  // The stage before the last reaches the cascade pin on each edge
  property p_cascade_step;
    s_rise |=> ser_out == $past(shift_r[sld_pkg::STAGES-2]);
  endproperty
  a_cascade_step: assert property (p_cascade_step) else $error("cascade missed stage"); // R2

  // One pin edge gives exactly one shift, a slow pin must not count twice
  property p_rise_once;
    s_rise |=> !rise;
  endproperty
  a_rise_once: assert property (p_rise_once) else $error("edge counted twice"); // R2

  // Outputs track the register while strobe and enable are both active
  property p_out_follow;
    stb && !oe_n |=> drv_out == shift_r;
  endproperty
  a_out_follow: assert property (p_out_follow) else $error("outputs not following"); // R5

  // Transparent path reaches the first output on the edge that shifts
  property p_transp_out;
    s_stb_held ##0 s_rise ##0 !oe_n |=> drv_out[0] == $past(data);
  endproperty
  a_transp_out: assert property (p_transp_out) else $error("output missed new bit"); // R5

  // Transparent latch moves its upper bits along with the register
  property p_latch_move;
    s_stb_held ##0 s_rise |=>
      latch_r[sld_pkg::STAGES-1:1] == $past(latch_r[sld_pkg::STAGES-2:0]);
  endproperty
  a_latch_move: assert property (p_latch_move) else $error("latch bits not moved"); // R5

  // Enabled outputs hold while strobe is low
  property p_out_hold;
    s_on_held ##0 !stb |=> $stable(drv_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("outputs drifted"); // R6

  // Shifting with strobe low must not reach the latch
  property p_rise_no_latch;
    s_rise ##0 !stb |=> $stable(latch_r) && shift_r[0] == $past(data);
  endproperty
  a_rise_no_latch: assert property (p_rise_no_latch) else $error("latch disturbed"); // R6

  // Disabled outputs with strobe low leave the latch alone
  property p_oe_storage;
    oe_n && !stb |=> $stable(latch_r);
  endproperty
  a_oe_storage: assert property (p_oe_storage) else $error("enable moved latch"); // R9

  // Outputs stay forced low for as long as enable stays high
  property p_off_hold;
    oe_n ##1 oe_n |-> drv_out == sld_pkg::OUT_OFF;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("outputs not held low"); // R8

  // Strobe rising copies the whole register at once
  property p_stb_rise;
    $rose(stb) |=> latch_r == shift_r;
  endproperty
  a_stb_rise: assert property (p_stb_rise) else $error("strobe copy missed"); // R4
endmodule // sld_top

// ===== tb/serial_in_latched_driver_tb.sv
/*
  Self-checking bench for the serial-in latched driver.
  Assumes the host model paces pins slowly against the system clock.
*/
`timescale 1ns/1ps
module serial_in_latched_driver_tb;
  logic clk = 1'b0;
  logic rst_n;
  logic ser_in, shift_clk, strobe, out_en_n, ser_out;
  logic [sld_pkg::STAGES-1:0] drv_out;
  int err_count = 0;
  int checked = 0;
  // 100 MHz system clock
  always #5 clk = ~clk;
  sld_host host (
    .clk(clk),
    .ser_in(ser_in),
    .shift_clk(shift_clk),
    .strobe(strobe),
    .out_en_n(out_en_n)
  );
  sld_top DUT (
    .clk(clk),
    .rst_n(rst_n),
    .ser_in(ser_in),
    .shift_clk(shift_clk),
    .strobe(strobe),
    .out_en_n(out_en_n),
    .ser_out(ser_out),
    .drv_out(drv_out)
  );
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Compare an 8-bit result
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Compare the cascade bit
  task automatic chk_bit(input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: cascade got %b expected %b", $time, got, exp);
    end
  endtask
  // Load a byte with strobe low, then latch it
  task automatic t_load();
    host.set_oe(1'b0);
    host.send_byte(8'hA5);
    chk(8'h00, drv_out);
    chk_bit(1'b1, ser_out);
    host.set_stb(1'b1);
    chk(8'hA5, drv_out);
    host.set_stb(1'b0);
    $display("load test done");
  endtask
  // Enable gates outputs only
  task automatic t_oe();
    host.set_oe(1'b1);
    chk(8'h00, drv_out);
    host.send_byte(8'h3C);
    chk_bit(1'b0, ser_out);
    host.set_oe(1'b0);
    chk(8'hA5, drv_out);
    $display("enable test done");
  endtask
  // Latch follows shifts while strobe stays high
  task automatic t_transp();
    host.set_stb(1'b1);
    chk(8'h3C, drv_out);
    host.send_bit(1'b1);
    chk(8'h79, drv_out);
    host.set_stb(1'b0);
    host.send_bit(1'b0);
    chk(8'h79, drv_out);
    chk_bit(1'b1, ser_out);
    $display("transparency test done");
  endtask
  // Strobe held high while loading, enable high hides the shifting bits
  task automatic t_tied();
    host.set_oe(1'b1);
    host.set_stb(1'b1);
    host.send_byte(8'h96);
    chk(8'h00, drv_out);
    chk_bit(1'b1, ser_out);
    host.set_oe(1'b0);
    chk(8'h96, drv_out);
    host.set_stb(1'b0);
    $display("strobe tied test done");
  endtask
  // Reset in mid-run clears storage, then loading works again
  task automatic t_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(8'h00, drv_out);
    chk_bit(1'b0, ser_out);
    host.set_stb(1'b1);
    host.send_byte(8'hC3);
    chk(8'hC3, drv_out);
    chk_bit(1'b1, ser_out);
    host.set_stb(1'b0);
    $display("reset test done");
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_load();
    t_oe();
    t_transp();
    t_tied();
    t_reset();
    stop_test();
  end
  // Watchdog well past the expected run
  initial begin
    #20us;
    err_count++;
    stop_test();
  end
endmodule // serial_in_latched_driver_tb

// ===== tb/sld_host.sv
/*
  Host model: drives serial data, shift clock, strobe and output enable.
  Assumes the system clock paces every step; shift clock idles low.
*/
`timescale 1ns/1ps
module sld_host (
  input wire logic clk,
  output logic ser_in,
  output logic shift_clk,
  output logic strobe,
  output logic out_en_n
);
  // Quiet pins at time zero
  initial begin
    ser_in = 1'b0;
    shift_clk = 1'b0;
    strobe = 1'b0;
    out_en_n = 1'b1;
  end
  // Wait n system cycles
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One 160 ns shift clock period
  task automatic send_bit(input logic b);
    idle(1);
    ser_in <= b;
    idle(7);
    shift_clk <= 1'b1;
    idle(8);
    shift_clk <= 1'b0;
    ser_in <= ~b; // Hold over, data no longer valid
  endtask
  // Earliest bit ends in the last stage
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      send_bit(v[i]);
    end
  endtask
  // Strobe level, then time for the sync path
  task automatic set_stb(input logic b);
    idle(1);
    strobe <= b;
    idle(8);
  endtask
  // Enable level, then time for the sync path
  task automatic set_oe(input logic b);
    idle(1);
    out_en_n <= b;
    idle(8);
  endtask
endmodule // sld_host
